/* File: bench/ipas_line_model.sv */
// peripheral interrupt line source facing the pending/active keeper
// assumes the bench calls its task from one process at a time
`timescale 1ns/1ps
`default_nettype none
module ipas_line_model
    import ipas_pkg::*;
(
    input wire logic sys_clk,
    output logic [NUM_CPU-1:0][31:0] ppiLine,
    output logic [31:0] spiLine
);
    // ------------------------------------------------------------
    // line levels
    // ------------------------------------------------------------
    initial
    begin
        ppiLine = '0;
        spiLine = '0;
    end

    // lines move just after an edge so the keeper samples a settled level
    task automatic setLine(input int id, input logic c, input logic v);
        @(posedge sys_clk);
        if (id < 32)
        begin
            ppiLine[c][id] <= v;
        end
        else
        begin
            spiLine[id-32] <= v;
        end
    endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the pending and active state keeper
// assumes the line model drives peripheral lines and one access at a time
`timescale 1ns/1ps
`default_nettype none
module tb
    import ipas_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CP1 = OFF_CLR_PEND + 12'h004;
    localparam logic [ADDR_W-1:0] SP1 = OFF_SET_PEND + 12'h004;
    localparam logic [ADDR_W-1:0] SA1 = OFF_SET_ACT + 12'h004;
    logic sys_clk;
    logic srst;
    ipas_req_s req;
    logic [31:0] rdData;
    logic [NUM_CPU-1:0][31:0] ppiLine;
    logic [31:0] spiLine;
    logic [NUM_CPU-1:0][NUM_SGI-1:0] sgiSetPend;
    logic [NUM_CPU-1:0][NUM_SGI-1:0] sgiClrPend;
    ipas_ack_s ack;
    logic [NUM_CPU-1:0][31:0] bankPending;
    logic [31:0] sharedPending;
    logic [NUM_CPU-1:0][31:0] bankActive;
    logic [31:0] sharedActive;
    int mismatches;
    int comparisons;

    ipas_pending_active dut_u (
        .sys_clk(sys_clk), .srst(srst), .req(req), .rdData(rdData),
        .ppiLine(ppiLine), .spiLine(spiLine), .sgiSetPend(sgiSetPend),
        .sgiClrPend(sgiClrPend), .ack(ack), .bankPending(bankPending), .sharedPending(sharedPending),
        .bankActive(bankActive), .sharedActive(sharedActive)
    );

    ipas_line_model lineModel (.sys_clk(sys_clk), .ppiLine(ppiLine), .spiLine(spiLine));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic c = 1'b0,
                      input logic n = 1'b0);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, cpu: c, nonSecure: n};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so look there and one later
    task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e,
                      input logic c = 1'b0, input logic n = 1'b0);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, cpu: c, nonSecure: n};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        check(nm, e, rdData);
        @(posedge sys_clk);
        #1;
        check({nm, " idle"}, 32'h0, rdData);
    endtask

    task automatic sgiPulse(input logic setNotClr);
        @(posedge sys_clk);
        if (setNotClr)
        begin
            sgiSetPend[1][3] <= 1'b1;
        end
        else
        begin
            sgiClrPend[1][3] <= 1'b1;
        end
        @(posedge sys_clk);
        sgiSetPend <= '0;
        sgiClrPend <= '0;
    endtask

    task automatic ackPulse(input logic c, input logic [ID_W-1:0] id);
        @(posedge sys_clk);
        ack <= '{valid: 1'b1, cpu: c, id: id};
        @(posedge sys_clk);
        ack.valid <= 1'b0;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // the tests need well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge sys_clk);
        mismatches++;
        final_report();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        srst = 1'b1;
        req = '0;
        sgiSetPend = '0;
        sgiClrPend = '0;
        ack = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        rd("pend reset", CP1, 32'h0);
        rd("act reset", SA1, 32'h0);
        $display("test reset done");

        wr(OFF_EDGE + 12'h004, 32'h00000001);
        lineModel.setLine(32, 1'b0, 1'b1);
        lineModel.setLine(32, 1'b0, 1'b0);
        rd("edge latched", CP1, 32'h1);
        wr(CP1, 32'h0);
        rd("zero write", CP1, 32'h1);
        wr(SA1, 32'h1);
        wr(CP1, 32'h1);
        rd("edge cleared", CP1, 32'h0);
        rd("active kept", SA1, 32'h1);
        $display("test edge done");

        lineModel.setLine(33, 1'b0, 1'b1);
        rd("level line", CP1, 32'h2);
        wr(CP1, 32'h2);
        rd("level held", CP1, 32'h2);
        lineModel.setLine(33, 1'b0, 1'b0);
        rd("level dropped", CP1, 32'h0);
        wr(SP1, 32'h4);
        rd("soft pending", CP1, 32'h4);
        rd("active only", SA1, 32'h1);
        wr(CP1, 32'h4);
        rd("soft cleared", CP1, 32'h0);
        $display("test level done");

        wr(SA1, 32'hf0000008);
        wr(SA1, 32'h00000008);
        wr(SA1, 32'h0);
        rd("active set", SA1, 32'h9);
        rd("ns group0", SA1, 32'h0, 1'b0, 1'b1);
        wr(OFF_GROUP + 12'h004, 32'h8);
        rd("ns group1", SA1, 32'h8, 1'b0, 1'b1);
        wr(SP1, 32'h10);
        wr(CP1, 32'h10, 1'b0, 1'b1);
        rd("ns clear", CP1, 32'h10);
        wr(CP1, 32'h10);
        $display("test active done");

        wr(SP1, 32'h20);
        ackPulse(1'b0, 6'h25);
        #1;
        check("ack pend out", 32'h0, sharedPending);
        check("ack act out", 32'h29, sharedActive);
        wr(OFF_CLR_ACT + 12'h004, 32'h20);
        rd("act cleared", SA1, 32'h9);
        $display("test ack done");

        lineModel.setLine(16, 1'b0, 1'b1);
        rd("ppi cpu0", OFF_CLR_PEND, 32'h00010000);
        rd("ppi cpu1", OFF_CLR_PEND, 32'h0, 1'b1);
        wr(OFF_SET_ACT, 32'h00100000, 1'b1);
        rd("act cpu1", OFF_SET_ACT, 32'h00100000, 1'b1);
        rd("act cpu0", OFF_SET_ACT, 32'h0);
        check("bank pend out", 32'h00010000, bankPending[0]);
        check("bank act out", 32'h00100000, bankActive[1]);
        sgiPulse(1'b1);
        rd("sgi pending", OFF_CLR_PEND, 32'h8, 1'b1);
        wr(OFF_CLR_PEND, 32'h8, 1'b1);
        rd("sgi clear", OFF_CLR_PEND, 32'h8, 1'b1);
        sgiPulse(1'b0);
        rd("sgi own clear", OFF_CLR_PEND, 32'h0, 1'b1);
        $display("test banked done");

        wr(OFF_SET_ACT + 12'h008, 32'hffffffff);
        rd("beyond words", OFF_SET_ACT + 12'h008, 32'h0);
        rd("no alias", OFF_SET_ACT, 32'h0);
        rd("unmapped", 12'h500, 32'h0);
        $display("test map done");
        final_report();
    end
endmodule
`default_nettype wire

/* File: include/ipas_pkg.sv */
// constants, field layouts and carriers of the pending/active state block
// assumes a fixed build of two processors and two words of interrupts
package ipas_pkg;

    // ------------------------------------------------------------
    // build size
    // ------------------------------------------------------------
    localparam int LINE_COUNT = 1;
    localparam int NUM_WORDS = LINE_COUNT + 1;
    localparam int NUM_CPU = 2;
    localparam int CPU_W = 1;
    localparam int ADDR_W = 12;
    localparam int ID_W = 6;
    localparam int NUM_SGI = 16;

    // ------------------------------------------------------------
    // register offsets (byte addresses, word n at base + 4*n)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_GROUP = 12'h080;
    localparam logic [ADDR_W-1:0] OFF_SET_PEND = 12'h200;
    localparam logic [ADDR_W-1:0] OFF_CLR_PEND = 12'h280;
    localparam logic [ADDR_W-1:0] OFF_SET_ACT = 12'h300;
    localparam logic [ADDR_W-1:0] OFF_CLR_ACT = 12'h380;
    localparam logic [ADDR_W-1:0] OFF_EDGE = 12'hc00;

    // ------------------------------------------------------------
    // field masks and reset values
    // ------------------------------------------------------------
    // interrupts 60..63 are not implemented
    localparam logic [NUM_WORDS-1:0][31:0] IMPL_MASK = {32'h0fffffff, 32'hffffffff};
    localparam logic [31:0] SGI_MASK = 32'h0000ffff;
    localparam logic [NUM_WORDS-1:0][31:0] EDGE_RESET = {32'h00000000, 32'h0000ffff};
    localparam logic [NUM_WORDS-1:0][31:0] GROUP_RESET = {32'h00000000, 32'h00000000};

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
        logic [CPU_W-1:0] cpu;
        logic nonSecure;
    } ipas_req_s;

    typedef struct packed {
        logic valid;
        logic [CPU_W-1:0] cpu;
        logic [ID_W-1:0] id;
    } ipas_ack_s;

endpackage

/* File: rtl/ipas_act_cell.sv */
// active state of one interrupt
// assumes strobes are one-cycle pulses on sys_clk
`timescale 1ns/1ps
`default_nettype none
module ipas_act_cell
    import ipas_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic setAct,
    input wire logic clrAct,
    output logic active
);
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            active <= 1'b0;
        else if (setAct) // see RL13
            active <= 1'b1;
        else if (clrAct)
            active <= 1'b0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    AST_ACT_SET: assert property (setAct |=> active) // see RL13
        else $error("set active did not activate");
    AST_ACT_HOLD: assert property (active && !clrAct |=> active) // see RL13
        else $error("active dropped without clear");
endmodule
`default_nettype wire

/* File: rtl/ipas_pend_cell.sv */
// pending state of one interrupt, edge or level behaviour
// assumes strobes are one-cycle pulses on sys_clk
`timescale 1ns/1ps
`default_nettype none
module ipas_pend_cell
    import ipas_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic isEdge,
    input wire logic line,
    input wire logic setPend,
    input wire logic clrPend,
    input wire logic ackTake,
    output logic pending
);
    logic lineDly;
    logic latch;
    logic lineRise;

    assign lineRise = line && !lineDly;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            lineDly <= 1'b0;
        else
            lineDly <= line;
    end

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            latch <= 1'b0;
        else if (setPend || (isEdge && lineRise)) // see RL8 see RL9
            latch <= 1'b1;
        else if (clrPend || ackTake) // see RL3 see RL4
            latch <= 1'b0;
    end

    // a level line is never latched, only a set is: a clear cannot beat a high line
    assign pending = latch || (!isEdge && line); // see RL5 see RL9

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    AST_EDGE_CLEAR: assert property (isEdge && clrPend && !setPend && !lineRise |=> !latch) // see RL3
        else $error("edge clear did not drop pending");
    AST_EDGE_LATCH: assert property (isEdge && lineRise ##1 isEdge |-> pending) // see RL8
        else $error("edge not latched");
    AST_LEVEL_HOLD: assert property (!isEdge && clrPend && line ##1 (!isEdge && line) |-> pending) // see RL5
        else $error("asserted level lost pending");
    AST_LEVEL_SWCLR: assert property (!isEdge && clrPend && !setPend ##1 (!isEdge && !line) |-> !pending) // see RL4
        else $error("software pending of level not cleared");
    AST_SET_LATCH: assert property (setPend |=> pending) // see RL9
        else $error("set pending not latched");
endmodule
`default_nettype wire

/* File: rtl/ipas_pending_active.sv */
// What this block does
// RL1: read zero when pending on no processor
// RL2: read one: banked per processor, shared anywhere
// RL3: edge clear drops pending, keeps active
// RL4: level pending from software cleared likewise
// RL5: asserted level line stays pending after clear
// RL6: clears of software interrupts are ignored
// RL7: clear word m/32 at 0x280, bit m%32
// RL8: edge pending latched by set or line
// RL9: level pending is latch or line
// RL10: unimplemented active bits read zero, ignore writes
// RL11: non-secure reads group 0 active as zero
// RL12: active bit reads active state only
// RL13: writing one activates; zero does nothing
// RL14: active words are line count plus one
// RL15: first active word banked per processor
// RL16: active word m/32 at 0x300, bit m%32
// RL17: active words are writable
// RL18: clear words count plus one, word zero banked
// RL19: unimplemented or hidden group 0 pending bits ignored
// RL20: software interrupt clear bits are read only
// RL21: single-cycle word access, state updated at once
//
// top of the pending and active state keeper, with its register port
// assumes synchronous inputs, one-cycle strobes and word-aligned accesses
`timescale 1ns/1ps
`default_nettype none
module ipas_pending_active
    import ipas_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire ipas_req_s req,
    output logic [31:0] rdData,
    input wire logic [NUM_CPU-1:0][31:0] ppiLine,
    input wire logic [31:0] spiLine,
    input wire logic [NUM_CPU-1:0][NUM_SGI-1:0] sgiSetPend,
    input wire logic [NUM_CPU-1:0][NUM_SGI-1:0] sgiClrPend,
    input wire ipas_ack_s ack,
    output logic [NUM_CPU-1:0][31:0] bankPending,
    output logic [31:0] sharedPending,
    output logic [NUM_CPU-1:0][31:0] bankActive,
    output logic [31:0] sharedActive
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic aligned;
    logic wordSel;
    logic hitGroup;
    logic hitSetPend;
    logic hitClrPend;
    logic hitSetAct;
    logic hitClrAct;
    logic hitEdge;
    logic anyHit;

    // two words per array, so bit 2 is the word index
    assign aligned = (req.addr[1:0] == 2'b00);
    assign wordSel = req.addr[2];
    assign hitGroup = aligned && (req.addr[ADDR_W-1:3] == OFF_GROUP[ADDR_W-1:3]);
    assign hitSetPend = aligned && (req.addr[ADDR_W-1:3] == OFF_SET_PEND[ADDR_W-1:3]);
    assign hitClrPend = aligned && (req.addr[ADDR_W-1:3] == OFF_CLR_PEND[ADDR_W-1:3]); // see RL7 see RL18
    assign hitSetAct = aligned && (req.addr[ADDR_W-1:3] == OFF_SET_ACT[ADDR_W-1:3]); // see RL16 see RL14
    assign hitClrAct = aligned && (req.addr[ADDR_W-1:3] == OFF_CLR_ACT[ADDR_W-1:3]);
    assign hitEdge = aligned && (req.addr[ADDR_W-1:3] == OFF_EDGE[ADDR_W-1:3]);
    assign anyHit = hitGroup || hitSetPend || hitClrPend || hitSetAct || hitClrAct || hitEdge;

    // ------------------------------------------------------------
    // configuration words: trigger mode and group
    // ------------------------------------------------------------
    logic [NUM_WORDS-1:0][31:0] edgeWord;
    logic [NUM_WORDS-1:0][31:0] groupWord;
    logic [31:0] accessMask;

    // software interrupts stay edge; the group word is secure-only
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            edgeWord <= EDGE_RESET;
        else if (req.wr && hitEdge)
            edgeWord[wordSel] <= (req.wdata & IMPL_MASK[wordSel]) | (wordSel ? 32'h00000000 : SGI_MASK);
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            groupWord <= GROUP_RESET;
        else if (req.wr && hitGroup && !req.nonSecure)
            groupWord[wordSel] <= req.wdata & IMPL_MASK[wordSel];
    end

    // bits reachable by this access: implemented, and group 1 when non-secure
    assign accessMask = IMPL_MASK[wordSel] & (req.nonSecure ? groupWord[wordSel] : 32'hffffffff); // see RL10 see RL19

    // ------------------------------------------------------------
    // write strobes per bit, applied in the cycle of the write
    // ------------------------------------------------------------
    logic [NUM_CPU-1:0][31:0] bankSetPend;
    logic [NUM_CPU-1:0][31:0] bankClrPend;
    logic [NUM_CPU-1:0][31:0] bankSetAct;
    logic [NUM_CPU-1:0][31:0] bankClrAct;
    logic [NUM_CPU-1:0][31:0] bankAck;
    logic [31:0] shSetPend;
    logic [31:0] shClrPend;
    logic [31:0] shSetAct;
    logic [31:0] shClrAct;
    logic [31:0] shAck;
    logic [31:0] wrBits;
    logic [31:0] ackBit;

    assign wrBits = req.wdata & accessMask; // see RL3 see RL13
    assign ackBit = 32'h00000001 << ack.id[4:0];

    always_comb
    begin
        for (int c = 0; c < NUM_CPU; c++)
        begin
            bankSetPend[c] = {16'h0000, sgiSetPend[c]};
            bankClrPend[c] = {16'h0000, sgiClrPend[c]};
            bankSetAct[c] = 32'h00000000;
            bankClrAct[c] = 32'h00000000;
            bankAck[c] = 32'h00000000;
            if (req.wr && !wordSel && (req.cpu == c[CPU_W-1:0]))
            begin
                // register writes never touch software interrupt pending
                if (hitSetPend)
                    bankSetPend[c] = bankSetPend[c] | (wrBits & ~SGI_MASK);
                if (hitClrPend)
                    bankClrPend[c] = bankClrPend[c] | (wrBits & ~SGI_MASK); // see RL6 see RL20
                if (hitSetAct)
                    bankSetAct[c] = wrBits; // see RL17 see RL21
                if (hitClrAct)
                    bankClrAct[c] = wrBits;
            end
            if (ack.valid && !ack.id[5] && (ack.cpu == c[CPU_W-1:0]))
                bankAck[c] = ackBit;
        end
    end

    always_comb
    begin
        shSetPend = 32'h00000000;
        shClrPend = 32'h00000000;
        shSetAct = 32'h00000000;
        shClrAct = 32'h00000000;
        shAck = 32'h00000000;
        if (req.wr && wordSel)
        begin
            if (hitSetPend)
                shSetPend = wrBits;
            if (hitClrPend)
                shClrPend = wrBits; // see RL3 see RL21
            if (hitSetAct)
                shSetAct = wrBits; // see RL17
            if (hitClrAct)
                shClrAct = wrBits;
        end
        if (ack.valid && ack.id[5])
            shAck = ackBit & IMPL_MASK[1];
    end

    // ------------------------------------------------------------
    // state cells: word zero banked per processor, word one shared
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CPU; c++)
    begin : g_bank
        for (genvar b = 0; b < 32; b++)
        begin : g_bit
            ipas_pend_cell u_pend (
                .sys_clk(sys_clk),
                .srst(srst),
                .isEdge(edgeWord[0][b]),
                .line((b >= NUM_SGI) ? ppiLine[c][b] : 1'b0),
                .setPend(bankSetPend[c][b]),
                .clrPend(bankClrPend[c][b]), // see RL18
                .ackTake(bankAck[c][b]),
                .pending(bankPending[c][b])
            );
            ipas_act_cell u_act (
                .sys_clk(sys_clk),
                .srst(srst),
                .setAct(bankSetAct[c][b] || bankAck[c][b]), // see RL15
                .clrAct(bankClrAct[c][b]),
                .active(bankActive[c][b])
            );
        end
    end

    for (genvar b = 0; b < 32; b++)
    begin : g_shared
        ipas_pend_cell u_pend (
            .sys_clk(sys_clk),
            .srst(srst),
            .isEdge(edgeWord[1][b]),
            .line(spiLine[b] && IMPL_MASK[1][b]),
            .setPend(shSetPend[b]),
            .clrPend(shClrPend[b]),
            .ackTake(shAck[b]),
            .pending(sharedPending[b])
        );
        ipas_act_cell u_act (
            .sys_clk(sys_clk),
            .srst(srst),
            .setAct(shSetAct[b] || shAck[b]),
            .clrAct(shClrAct[b]),
            .active(sharedActive[b])
        );
    end

    // ------------------------------------------------------------
    // read path: data one cycle after the strobe, zero otherwise
    // ------------------------------------------------------------
    logic [31:0] pendView;
    logic [31:0] actView;
    logic [31:0] next_rdData;

    // banked word shows the reader's own copy, shared word any processor
    assign pendView = wordSel ? sharedPending : bankPending[req.cpu]; // see RL1 see RL2
    assign actView = wordSel ? sharedActive : bankActive[req.cpu]; // see RL12

    always_comb
    begin
        next_rdData = 32'h00000000;
        if (req.rd)
        begin
            if (hitSetPend || hitClrPend)
                next_rdData = pendView & accessMask; // see RL19
            else if (hitSetAct || hitClrAct)
                next_rdData = actView & accessMask; // see RL10 see RL11
            else if (hitEdge)
                next_rdData = edgeWord[wordSel] & accessMask;
            else if (hitGroup)
                next_rdData = req.nonSecure ? 32'h00000000 : groupWord[wordSel];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdData <= 32'h00000000;
        else
            rdData <= next_rdData;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_rd_shared_act_ns;
        req.rd && hitSetAct && wordSel && req.nonSecure;
    endsequence

    // nothing on its own clear path may drop processor 1 software pending
    sequence s_sgi_quiet;
        sgiClrPend[1] == 16'h0000 && !(ack.valid && !ack.id[5] && ack.cpu == 1'b1);
    endsequence

    AST_UNMAPPED_ZERO: assert property (req.rd && !anyHit |=> rdData == 32'h00000000)
        else $error("unmapped read not zero");
    AST_NO_READ_ZERO: assert property (!req.rd |=> rdData == 32'h00000000)
        else $error("read data outside the answer cycle");
    AST_NS_GROUP0_ZERO: assert property (s_rd_shared_act_ns |=> (rdData & ~$past(groupWord[1])) == 32'h00000000) // see RL11
        else $error("group 0 active visible to non-secure read");
    AST_UNIMPL_ZERO: assert property (req.rd && wordSel |=> (rdData & ~IMPL_MASK[1]) == 32'h00000000) // see RL10
        else $error("unimplemented bits read nonzero");
    AST_ACT_READ: assert property (req.rd && hitSetAct && wordSel && !req.nonSecure // see RL12
                                   |=> rdData == $past(sharedActive & IMPL_MASK[1]))
        else $error("active read mismatch");
    AST_PEND_READ_BANK: assert property (req.rd && hitClrPend && !wordSel && !req.nonSecure // see RL2
                                         |=> rdData == $past(bankPending[req.cpu]))
        else $error("banked pending read mismatch");

    // banked active word shows only the reader's own copy
    AST_ACT_READ_BANK: assert property (req.rd && hitSetAct && !wordSel && !req.nonSecure // see RL15
                                        |=> rdData == $past(bankActive[req.cpu]))
        else $error("banked active read mismatch");
    AST_SGI_IGNORE: assert property ((req.wr && hitClrPend && !wordSel && req.cpu == 1'b1) and s_sgi_quiet // see RL6
                                     |=> (~bankPending[1][15:0] & $past(bankPending[1][15:0])) == 16'h0000)
        else $error("software interrupt cleared by clear word");
    AST_WRITE_ACTIVATES: assert property (req.wr && hitSetAct && wordSel && !req.nonSecure && req.wdata[0] // see RL13
                                          |=> sharedActive[0])
        else $error("set active write did not activate");
endmodule
`default_nettype wire
